// ### logic/amebc_top.sv
`timescale 1ns/100ps
`include "amebc_defines.svh"
module amebc_top (
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     req_valid_in,
  input  wire amebc_pkg::amebc_req_t    req_in,
  output logic                          req_ready_out,
  output logic                          rsp_valid_out,
  output logic [15:0]                   rsp_rdata_out,
  output logic                          rsp_trap_out,
  input  wire logic                     single_chip_in,
  input  wire logic [3:0]               seg_lines_in,
  input  wire amebc_pkg::amebc_win_t [3:0]  window_addr_select_in,
  input  wire amebc_pkg::amebc_tcfg_t [3:0] window_timing_cfg_in,
  input  wire amebc_pkg::amebc_fcfg_t [3:0] window_function_cfg_in,
  input  wire amebc_pkg::amebc_tcfg_t   default_timing_cfg_in,
  input  wire amebc_pkg::amebc_fcfg_t   default_function_cfg_in,
  output logic                          int_req_out,
  output amebc_pkg::amebc_tgt_t         int_route_out,
  output logic                          int_alt_path_out,
  output amebc_pkg::amebc_req_t         int_cmd_out,
  input  wire logic                     int_ack_in,
  input  wire logic [15:0]              int_rdata_in,
  input  wire logic                     int_defined_in,
  output logic                          pipe_hold_out,
  output logic                          bus_ref_clk_out,
  output logic [15:0]                   addr_out_port_out,
  input  wire logic [15:0]              addr_data_port_in,
  output logic [15:0]                   addr_data_port_out,
  output logic [1:0]                    addr_data_port_oe_n_out,
  output logic [7:0]                    seg_addr_out,
  output logic                          ale_out,
  output logic                          rd_n_out,
  output logic                          wr_n_out,
  output logic [3:0]                    cs_n_out
);
  import amebc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [23:0] a = req_in.addr;
  wire in_ext0  = a <= `AMEBC_EXT0_END;
  wire in_seg0  = !in_ext0 && a <= `AMEBC_SEG0_END;
  wire in_ext1  = a > `AMEBC_SEG0_END && a <= `AMEBC_EXT1_END;
  wire in_can   = a >= `AMEBC_CAN_LO && a <= `AMEBC_CAN_END;
  wire in_extio = a > `AMEBC_CAN_END && a <= `AMEBC_EXTIO_END;
  wire in_ext2  = a >= `AMEBC_EXT2_LO && a <= `AMEBC_EXT2_END;
  wire in_flash = a >= `AMEBC_FLASH_LO && a <= `AMEBC_FLASH_END;
  wire in_pram  = a >= `AMEBC_PRAM_LO && a <= `AMEBC_PRAM_END;
  wire in_pralt = a >= `AMEBC_PRALT_LO && a <= `AMEBC_PRALT_END;
  wire in_freg  = a >= `AMEBC_FREG_LO;
  wire ext_mem  = (in_ext0 || in_ext1 || in_ext2) && !single_chip_in;
  wire ext_io   = in_extio && !single_chip_in;
  amebc_tgt_t dec_tgt;
  assign dec_tgt = ext_mem ? TGT_EXT :
                   ext_io ? TGT_EXTIO :
                   in_can ? TGT_LX :
                   in_seg0 ? TGT_SEG0 :
                   in_flash ? TGT_FLASH :
                   (in_pram || in_pralt) ? TGT_PRAM :
                   in_freg ? TGT_FREG : TGT_TRAP;

  ////////////////////////////////////////////////////////////////////////
  // Window match and priority
  logic [3:0] hit;
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++) begin : g_win
      wire [11:0] wmask = 12'hfff << window_addr_select_in[gw].size;
      assign hit[gw] = window_addr_select_in[gw].en &&
        (((a[23:12] ^ window_addr_select_in[gw].base) & wmask) == 12'h000);
    end
  endgenerate
  wire [1:0] wsel = hit[3] ? 2'h3 : hit[2] ? 2'h2 :
                    hit[1] ? 2'h1 : 2'h0;
  wire any_hit = |hit;
  wire [2:0] dec_win = any_hit ? {1'b0, wsel} + 3'h1 : 3'h0;
  amebc_tcfg_t sel_t;
  amebc_fcfg_t sel_f;
  assign sel_t = any_hit ? window_timing_cfg_in[wsel]
                         : default_timing_cfg_in;
  assign sel_f = any_hit ? window_function_cfg_in[wsel]
                         : default_function_cfg_in;

  ////////////////////////////////////////////////////////////////////////
  // Reference clock divider
  logic [3:0] div_cnt;
  wire [3:0] next_div_cnt = div_cnt + 4'h1;
  wire tick = div_cnt == `AMEBC_REF_RISE;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      div_cnt <= 4'h0;
      bus_ref_clk_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      bus_ref_clk_out <= next_div_cnt[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  logic [15:0] ad_meta;
  logic [15:0] ad_sync;
  always_ff @(posedge core_clk_in) begin
    ad_meta <= addr_data_port_in;
    ad_sync <= ad_meta;
  end

  ////////////////////////////////////////////////////////////////////////
  // Access state
  amebc_state_t state;
  amebc_req_t   cur;
  amebc_tgt_t   tgt;
  amebc_tcfg_t  cur_t;
  amebc_fcfg_t  cur_f;
  logic [2:0]   cur_win;
  logic         started;
  logic         second;
  logic [3:0]   ph;
  logic [15:0]  lx_data;
  wire take   = req_valid_in && req_ready_out;
  wire mode8  = cur_f.mode == MODE_D8_MUX || cur_f.mode == MODE_D8_DEMUX;
  wire muxed  = cur_f.mode == MODE_D16_MUX || cur_f.mode == MODE_D8_MUX;
  wire is_lx  = tgt == TGT_LX;
  wire split  = mode8 && !cur.byte_acc && !second;
  wire [23:0] bus_addr = {cur.addr[23:1], cur.addr[0] | second};
  wire [7:0] seg_mask = ~(8'hff << seg_lines_in);
  wire [15:0] pin_rd = is_lx ? lx_data : ad_sync;
  wire [15:0] rd_word = mode8 ? (second ? {pin_rd[7:0], rsp_rdata_out[7:0]}
                                        : {8'h00, pin_rd[7:0]}) :
                        cur.byte_acc ? {8'h00, cur.addr[0] ? pin_rd[15:8]
                                                           : pin_rd[7:0]} :
                        pin_rd;
  wire [15:0] wr_word = mode8 ? {8'h00, second ? cur.wdata[15:8]
                                               : cur.wdata[7:0]} :
                        cur.byte_acc ? {cur.wdata[7:0], cur.wdata[7:0]} :
                        cur.wdata;
  wire [1:0] oe_data = mode8 ? 2'b10 : 2'b00;
  wire [3:0] cs_sel = !cur_f.cs_en ? 4'hf :
                      cur_win == 3'h0 ? 4'he :
                      cur_win == 3'h4 ? 4'hf :
                      ~(4'h1 << cur_win[1:0]);
  wire int_rd_val = tgt == TGT_FREG && !int_defined_in && !cur.write;
  assign int_cmd_out = cur;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      cur <= '0;
      tgt <= TGT_TRAP;
      cur_t <= '0;
      cur_f <= '0;
      cur_win <= 3'h0;
      started <= 1'b0;
      second <= 1'b0;
      ph <= 4'h0;
      lx_data <= 16'h0000;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 16'h0000;
      rsp_trap_out <= 1'b0;
      int_req_out <= 1'b0;
      int_route_out <= TGT_TRAP;
      int_alt_path_out <= 1'b0;
      pipe_hold_out <= 1'b0;
      addr_out_port_out <= 16'h0000;
      addr_data_port_out <= 16'h0000;
      addr_data_port_oe_n_out <= 2'b11;
      seg_addr_out <= 8'h00;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      cs_n_out <= 4'hf;
    end else begin
      rsp_valid_out <= 1'b0;
      int_req_out <= 1'b0;
      if (is_lx && int_ack_in) begin
        lx_data <= int_rdata_in;
      end
      case (state)
        ST_IDLE: begin
          req_ready_out <= 1'b1;
          if (take) begin
            req_ready_out <= 1'b0;
            rsp_trap_out <= 1'b0;
            cur <= req_in;
            tgt <= dec_tgt;
            cur_t <= sel_t;
            cur_f <= sel_f;
            cur_win <= dec_win;
            started <= 1'b0;
            second <= 1'b0;
            int_route_out <= dec_tgt;
            int_alt_path_out <= in_pralt;
            pipe_hold_out <= dec_tgt == TGT_EXTIO;
            if (dec_tgt == TGT_TRAP) begin
              rsp_trap_out <= 1'b1;
              state <= ST_DONE;
            end else if (dec_tgt == TGT_EXT || dec_tgt == TGT_EXTIO ||
                         dec_tgt == TGT_LX) begin
              state <= ST_ADDR;
            end else begin
              int_req_out <= 1'b1;
              state <= ST_INT;
            end
          end
        end
        ST_INT: begin
          if (int_ack_in) begin
            rsp_rdata_out <= int_rd_val ? `AMEBC_TRAP_CODE
                                        : int_rdata_in;
            state <= ST_DONE;
          end
        end
        ST_ADDR: begin
          if (tick) begin
            if (!started) begin
              started <= 1'b1;
              ph <= {2'b00, cur_t.addr_cyc};
              if (!is_lx) begin
                ale_out <= 1'b1;
                cs_n_out <= cs_sel;
                seg_addr_out <= bus_addr[23:16] & seg_mask;
                if (muxed) begin
                  addr_data_port_out <= bus_addr[15:0];
                  addr_data_port_oe_n_out <= 2'b00;
                end else begin
                  addr_out_port_out <= bus_addr[15:0];
                end
              end
            end else if (ph != 4'h0) begin
              ph <= ph - 4'h1;
            end else begin
              ph <= cur_t.wait_cyc;
              ale_out <= 1'b0;
              state <= ST_DATA;
              if (is_lx) begin
                int_req_out <= 1'b1;
              end else if (cur.write) begin
                wr_n_out <= 1'b0;
                addr_data_port_out <= wr_word;
                addr_data_port_oe_n_out <= oe_data;
              end else begin
                rd_n_out <= 1'b0;
                addr_data_port_oe_n_out <= 2'b11;
              end
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            if (ph != 4'h0) begin
              ph <= ph - 4'h1;
            end else begin
              rd_n_out <= 1'b1;
              wr_n_out <= 1'b1;
              addr_data_port_oe_n_out <= 2'b11;
              if (!cur.write) begin
                rsp_rdata_out <= rd_word;
              end
              if (split && !is_lx) begin
                second <= 1'b1;
                started <= 1'b0;
                state <= ST_ADDR;
              end else begin
                cs_n_out <= 4'hf;
                state <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          rsp_valid_out <= 1'b1;
          pipe_hold_out <= 1'b0;
          req_ready_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_trap_region_resp: assert property (
    take && dec_tgt == TGT_TRAP |-> ##2 rsp_valid_out && rsp_trap_out)
    else $error("reserved access did not trap");
  a_can_route_lx: assert property (
    take && a >= 24'h200000 && a <= 24'h2007ff |=> tgt == TGT_LX)
    else $error("CAN window not routed to internal bus");
  a_ext_low_route: assert property (
    take && a < 24'h008000 && !single_chip_in |=> tgt == TGT_EXT)
    else $error("low external region not external");
  a_seg0_route: assert property (
    take && a[23:15] == 9'h001 |=> tgt == TGT_SEG0)
    else $error("system segment not internal");
  a_freg_trap_code: assert property (
    state == ST_INT && int_ack_in && int_rd_val |->
    ##2 rsp_valid_out && rsp_rdata_out == 16'h9b9b)
    else $error("undefined flash register read not trapped");
  a_win_priority: assert property (
    take && hit[3] |=> cur_win == 3'h4)
    else $error("window four did not win");
  a_win4_no_cs: assert property (
    ale_out && cur_win == 3'h4 |-> cs_n_out == 4'hf)
    else $error("window four drove a chip select");
  a_ale_on_ref: assert property (
    $rose(ale_out) |-> $rose(bus_ref_clk_out))
    else $error("address strobe not on reference rising edge");
  a_io_pipe_hold: assert property (
    state != ST_IDLE && tgt == TGT_EXTIO |-> pipe_hold_out)
    else $error("pipeline not held for external IO");
  a_mux_addr_out: assert property (
    ale_out && muxed |-> addr_data_port_out == bus_addr[15:0])
    else $error("multiplexed address not on shared port");
  a_pram_alt_path: assert property (
    take && a >= 24'hf80000 && a <= 24'hf817ff |=>
    int_alt_path_out && tgt == TGT_PRAM)
    else $error("alternate program RAM path not flagged");
  a_single_chip_trap: assert property (
    take && single_chip_in && in_ext2 |=> tgt == TGT_TRAP)
    else $error("external access in single chip mode not trapped");
  a_seg_line_mask: assert property (
    ale_out |-> (seg_addr_out & ~seg_mask) == 8'h00)
    else $error("inactive segment line driven");
  a_default_cs: assert property (
    $rose(ale_out) && cur_win == 3'h0 && cur_f.cs_en |-> cs_n_out == 4'he)
    else $error("default region chip select wrong");
  a_io_route: assert property (
    take && a >= 24'h200800 && a <= 24'h3fffff && !single_chip_in |=>
    tgt == TGT_EXTIO && pipe_hold_out)
    else $error("external IO access not held in order");
  a_demux_addr: assert property (
    ale_out && !muxed |-> addr_out_port_out == bus_addr[15:0])
    else $error("demultiplexed address not on address port");

  c_ext_read: cover property (
    state == ST_DATA && tick && ph == 4'h0 && !cur.write && tgt == TGT_EXT);
  c_split_word: cover property (second && ale_out);
  c_trap_read: cover property (rsp_valid_out && rsp_trap_out);
  c_io_access: cover property (state == ST_DATA && tgt == TGT_EXTIO);
endmodule

// ### logic/amebc_defines.svh
// How it works
// - Decode 16 Mbyte map of 64K segments
// - Byte and word access everywhere
// - Data memories and register areas in segment 0
// - Undefined flash register reads return trap code
// - External memory and IO regions use external bus
// - Program RAM plus alternate slower path
// - CAN window goes over internal peripheral bus
// - External IO holds core pipeline in order
// - Single chip or four bus modes
// - Demux: address port plus data port
// - Mux: address then data on one port
// - Selectable count of segment address lines
// - Three window chip selects plus default
// - Timing per region from configuration
// - Window priority four, three, two, one
// - Unmatched addresses use default configuration
// - Window four has no chip select pin
// - Bus timing follows reference clock rising edge
// - Bus mode switches per access window
// - Internal bus accesses use same protocol
`ifndef AMEBC_DEFINES_SVH
`define AMEBC_DEFINES_SVH
`define AMEBC_EXT0_END   24'h007fff
`define AMEBC_SEG0_END   24'h00ffff
`define AMEBC_EXT1_END   24'h1fffff
`define AMEBC_CAN_LO     24'h200000
`define AMEBC_CAN_END    24'h2007ff
`define AMEBC_EXTIO_END  24'h3fffff
`define AMEBC_EXT2_LO    24'h400000
`define AMEBC_EXT2_END   24'hbeffff
`define AMEBC_FLASH_LO   24'hc00000
`define AMEBC_FLASH_END  24'hc3ffff
`define AMEBC_PRAM_LO    24'he00000
`define AMEBC_PRAM_END   24'he017ff
`define AMEBC_PRALT_LO   24'hf80000
`define AMEBC_PRALT_END  24'hf817ff
`define AMEBC_FREG_LO    24'hfff000
`define AMEBC_TRAP_CODE  16'h9b9b
`define AMEBC_REF_DIV    16
`define AMEBC_REF_RISE   4'h7
`endif

// ### logic/amebc_pkg.sv
package amebc_pkg;
  typedef enum logic [2:0] {
    TGT_TRAP  = 3'h0,
    TGT_EXT   = 3'h1,
    TGT_EXTIO = 3'h2,
    TGT_LX    = 3'h3,
    TGT_SEG0  = 3'h4,
    TGT_FLASH = 3'h5,
    TGT_PRAM  = 3'h6,
    TGT_FREG  = 3'h7
  } amebc_tgt_t;
  typedef enum logic [1:0] {
    MODE_D16_DEMUX = 2'h0,
    MODE_D16_MUX   = 2'h1,
    MODE_D8_MUX    = 2'h2,
    MODE_D8_DEMUX  = 2'h3
  } amebc_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_DONE = 3'h2,
    ST_INT  = 3'h6
  } amebc_state_t;
  typedef struct packed {
    logic        en;
    logic [11:0] base;
    logic [3:0]  size;
  } amebc_win_t;
  typedef struct packed {
    logic [3:0] wait_cyc;
    logic [1:0] addr_cyc;
  } amebc_tcfg_t;
  typedef struct packed {
    amebc_mode_t mode;
    logic        cs_en;
  } amebc_fcfg_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        byte_acc;
  } amebc_req_t;
endpackage

// ### tb/amebc_ext_mem.sv
`timescale 1ns/100ps
module amebc_ext_mem (
  input  wire logic        ref_clk_in,
  input  wire logic        mux_in,
  input  wire logic        ale_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] ad_in,
  input  wire logic [7:0]  seg_in,
  input  wire logic [3:0]  cs_n_in,
  output logic      [15:0] ad_out,
  output logic      [15:0] addr_seen_out,
  output logic      [15:0] wdata_seen_out,
  output logic      [7:0]  seg_seen_out,
  output logic      [3:0]  cs_seen_out
);
  logic [15:0] mem_data;
  assign mem_data = {addr_seen_out[7:0], addr_seen_out[15:8]} ^ 16'h3c5a;
  initial begin
    ad_out = 16'h5a5a;
    addr_seen_out = 16'h0000;
    wdata_seen_out = 16'h0000;
    seg_seen_out = 8'h00;
    cs_seen_out = 4'hf;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sample mid ref period, away from the launching edge
  always @(negedge ref_clk_in) begin
    if (ale_in) begin
      addr_seen_out <= mux_in ? ad_in : addr_in;
      seg_seen_out <= seg_in;
      cs_seen_out <= cs_n_in;
    end
    if (!wr_n_in) wdata_seen_out <= ad_in;
  end
  always @(negedge rd_n_in) begin
    ad_out = mem_data;
  end
  // Short hold, then a value that cannot pass for data
  always @(posedge rd_n_in) begin
    #8 ad_out = ~ad_out;
  end
endmodule

// ### tb/amebc_top_tb.sv
`timescale 1ns/100ps
`include "amebc_defines.svh"
module amebc_top_tb;
  import amebc_pkg::*;
  logic core_clk_in, reset_n_in, req_valid_in, single_chip_in, int_ack_in;
  logic int_defined_in, req_ready_out, rsp_valid_out, rsp_trap_out;
  logic int_req_out, int_alt_path_out, pipe_hold_out, bus_ref_clk_out;
  logic ale_out, rd_n_out, wr_n_out, mux, tp, hold, prev_ref;
  logic [3:0]  seg_lines_in, cs_n_out, cs_seen;
  logic [1:0]  addr_data_port_oe_n_out;
  logic [7:0]  seg_addr_out, seg_seen;
  logic [6:0]  pins, prev_pins;
  logic [15:0] rsp_rdata_out, int_rdata_in, addr_out_port_out, wd, rd;
  logic [15:0] addr_data_port_in, addr_data_port_out, mem_ad, addr_seen;
  logic [15:0] wdata_seen, int_data;
  logic [23:0] a;
  amebc_req_t        req_in, int_cmd_out;
  amebc_tgt_t        int_route_out;
  amebc_win_t [3:0]  window_addr_select_in;
  amebc_tcfg_t [3:0] window_timing_cfg_in;
  amebc_fcfg_t [3:0] window_function_cfg_in;
  amebc_tcfg_t       default_timing_cfg_in;
  amebc_fcfg_t       default_function_cfg_in;
  int miscompares, n_tests, seed, lat, rd_low, ref_gap;
  logic [23:0] trap_a [6] = '{24'hbf0000, 24'hc40000, 24'he01800,
                              24'hf81800, 24'hfe0000, 24'h400000};
  logic [23:0] int_a [6] = '{24'h008000, 24'h200000, 24'hc00000,
                             24'he00000, 24'hf80000, 24'hfff000};
  amebc_tgt_t int_t [6] = '{TGT_SEG0, TGT_LX, TGT_FLASH, TGT_PRAM,
                            TGT_PRAM, TGT_FREG};
  logic [23:0] win_a [7] = '{24'h020000, 24'h010000, 24'h040000,
                             24'h030000, 24'h150000, 24'h3f0000,
                             24'h000000};
  int win_m [7] = '{1, 3, 2, 0, 0, 0, 1};
  logic [3:0] win_cs [7] = '{4'hd, 4'hb, 4'h7, 4'hf, 4'he, 4'he, 4'hd};
  assign addr_data_port_in = {
    addr_data_port_oe_n_out[1] ? mem_ad[15:8] : addr_data_port_out[15:8],
    addr_data_port_oe_n_out[0] ? mem_ad[7:0] : addr_data_port_out[7:0]};
  assign pins = {rd_n_out, wr_n_out, ale_out, cs_n_out};
  amebc_top amebc_top_inst (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .rsp_trap_out(rsp_trap_out), .single_chip_in(single_chip_in),
    .seg_lines_in(seg_lines_in),
    .window_addr_select_in(window_addr_select_in),
    .window_timing_cfg_in(window_timing_cfg_in),
    .window_function_cfg_in(window_function_cfg_in),
    .default_timing_cfg_in(default_timing_cfg_in),
    .default_function_cfg_in(default_function_cfg_in),
    .int_req_out(int_req_out), .int_route_out(int_route_out),
    .int_alt_path_out(int_alt_path_out), .int_cmd_out(int_cmd_out),
    .int_ack_in(int_ack_in), .int_rdata_in(int_rdata_in),
    .int_defined_in(int_defined_in), .pipe_hold_out(pipe_hold_out),
    .bus_ref_clk_out(bus_ref_clk_out),
    .addr_out_port_out(addr_out_port_out),
    .addr_data_port_in(addr_data_port_in),
    .addr_data_port_out(addr_data_port_out),
    .addr_data_port_oe_n_out(addr_data_port_oe_n_out),
    .seg_addr_out(seg_addr_out), .ale_out(ale_out), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .cs_n_out(cs_n_out));
  amebc_ext_mem amebc_ext_mem_inst (.ref_clk_in(bus_ref_clk_out),
    .mux_in(mux), .ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .addr_in(addr_out_port_out), .ad_in(addr_data_port_in),
    .seg_in(seg_addr_out), .cs_n_in(cs_n_out), .ad_out(mem_ad),
    .addr_seen_out(addr_seen), .wdata_seen_out(wdata_seen),
    .seg_seen_out(seg_seen), .cs_seen_out(cs_seen));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ev(input logic [15:0] x);
    return {x[7:0], x[15:8]} ^ 16'h3c5a;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [15:0] x, input int m);
    return m > 1 ? (ev(x | 16'h1) << 8) | (ev(x) & 16'h00ff) : ev(x);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic access(input logic [23:0] ad, input logic w,
                        input logic b, input logic [15:0] d);
    int n;
    n = 0;
    hold = 0;
    @(posedge core_clk_in);
    #1 req_valid_in = 1;
    req_in = '{addr: ad, wdata: d, write: w, byte_acc: b};
    rd_low = 0;
    @(posedge core_clk_in);
    while (req_ready_out !== 1'b1 && n++ < 100) @(posedge core_clk_in);
    #1 req_valid_in = 0;
    lat = 0;
    while (rsp_valid_out !== 1'b1 && lat < 3000) begin
      @(posedge core_clk_in);
      #1 lat++;
      hold |= pipe_hold_out;
    end
    rd = rsp_rdata_out;
    tp = rsp_trap_out;
    if (lat >= 3000 || n > 100) chk("handshake", 0, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Internal targets answer two cycles after the request
  always @(posedge core_clk_in) begin
    if (int_req_out === 1'b1) begin
      repeat (2) @(posedge core_clk_in);
      #1 int_ack_in = 1;
      int_rdata_in = int_data;
      @(posedge core_clk_in);
      #1 int_ack_in = 0;
    end
  end
  // Pins move only with the ref clock rise
  always @(posedge core_clk_in) begin
    if (reset_n_in === 1'b1) begin
      ref_gap++;
      if (pins !== prev_pins && !(bus_ref_clk_out && !prev_ref))
        chk("pin_edge", 0, 1);
      if (bus_ref_clk_out && !prev_ref) begin
        if (ref_gap < 40) chk("ref_period", `AMEBC_REF_DIV, ref_gap);
        ref_gap = 0;
      end
      if (rd_n_out === 1'b0) rd_low++;
    end
    prev_pins = pins;
    prev_ref = bus_ref_clk_out;
  end
  initial begin
    core_clk_in = 0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h9756;
    miscompares = 0;
    n_tests = 0;
    ref_gap = 99;
    reset_n_in = 0;
    req_valid_in = 0;
    req_in = '0;
    single_chip_in = 0;
    seg_lines_in = 4'h8;
    int_ack_in = 0;
    int_rdata_in = 16'h0000;
    int_defined_in = 1;
    int_data = 16'h0000;
    mux = 0;
    window_addr_select_in = '0;
    window_timing_cfg_in = '0;
    window_function_cfg_in = '0;
    default_timing_cfg_in = '0;
    default_function_cfg_in = '{MODE_D16_DEMUX, 1'b1};
    repeat (6) @(posedge core_clk_in);
    chk("rst_cs", 16'hf, cs_n_out);
    chk("rst_oe", 16'h3, addr_data_port_oe_n_out);
    #1 reset_n_in = 1;
    repeat (2) @(posedge core_clk_in);
    foreach (trap_a[i]) begin
      single_chip_in = (i == 5);
      access(trap_a[i] | (24'($random(seed)) & 24'h0007fe), 0, 0, 16'h0000);
      chk("trap", 1, tp);
      chk("trap_lat", 1, lat <= 3);
    end
    single_chip_in = 0;
    $display("test traps done");
    foreach (int_a[i]) begin
      int_data = 16'($random(seed));
      int_defined_in = (i != 5);
      a = int_a[i] | (24'($random(seed)) & 24'h0007fe);
      access(a, 0, 0, 16'h0000);
      chk("int_cmd", a[15:0], int_cmd_out.addr[15:0]);
      chk("route", int_t[i], int_route_out);
      chk("alt", i == 4, int_alt_path_out);
      chk("int_rd", i == 5 ? `AMEBC_TRAP_CODE : int_data, rd);
    end
    $display("test internal done");
    for (int m = 0; m < 4; m++) begin
      default_function_cfg_in.mode = amebc_mode_t'(m);
      default_timing_cfg_in = 6'($random(seed));
      mux = (m == 1 || m == 2);
      a = 24'h400000 | (24'($random(seed)) & 24'h3ffffe);
      access(a, 0, 0, 16'h0000);
      chk("ext_rd", exp_rd(a[15:0], m), rd);
      chk("seg", a[23:16], seg_seen);
      if (m == 0) chk("rd_width",
        (default_timing_cfg_in.wait_cyc + 1) * `AMEBC_REF_DIV,
        rd_low);
      wd = 16'($random(seed));
      a = a | {23'h0, m > 1};
      access(a, 1, m > 1, wd);
      chk("wr_data", m > 1 ? wd & 16'hff : wd,
          m > 1 ? wdata_seen & 16'hff : wdata_seen);
      chk("wr_addr", a[15:0], addr_seen);
    end
    $display("test modes done");
    default_function_cfg_in = '{MODE_D16_DEMUX, 1'b1};
    default_timing_cfg_in = '0;
    window_addr_select_in[0] = '{1'b1, 12'h000, 4'h8};
    window_addr_select_in[1] = '{1'b1, 12'h010, 4'h4};
    window_addr_select_in[2] = '{1'b1, 12'h040, 4'h4};
    window_addr_select_in[3] = '{1'b1, 12'h030, 4'h4};
    window_function_cfg_in[0] = '{MODE_D16_MUX, 1'b1};
    window_function_cfg_in[1] = '{MODE_D8_DEMUX, 1'b1};
    window_function_cfg_in[2] = '{MODE_D8_MUX, 1'b1};
    window_function_cfg_in[3] = '{MODE_D16_DEMUX, 1'b1};
    foreach (win_a[i]) begin
      a = win_a[i] | (24'($random(seed)) & 24'h007ffe);
      mux = (win_m[i] == 1 || win_m[i] == 2);
      access(a, 0, 0, 16'h0000);
      chk("win_rd", exp_rd(a[15:0], win_m[i]), rd);
      chk("cs", win_cs[i], cs_seen);
      chk("io_hold", i == 5, hold);
    end
    seg_lines_in = 4'h4;
    mux = 0;
    access(24'h5a1230, 0, 0, 16'h0000);
    chk("seg_lines", 16'h000a, seg_seen);
    $display("test windows done");
    end_of_test();
  end
endmodule
